/* File: design/cpwe_regs.svh */
// Timing constants and option codes for the crank pulse width encoder.
// Included by design files; definitions only.
`ifndef CPWE_REGS_SVH
`define CPWE_REGS_SVH

// Clock rate in kHz (50 MHz)
`define CPWE_CLK_KHZ        50000
// Cycles per microsecond, derived from the clock rate
`define CPWE_CYC_PER_US     (`CPWE_CLK_KHZ / 1000)

// Typical pulse widths in microseconds
`define CPWE_T22_US         22
`define CPWE_T30_US         30
`define CPWE_T45_US         45
`define CPWE_T60_US         60
`define CPWE_T75_US         75
`define CPWE_T90_US         90
`define CPWE_T120_US        120
`define CPWE_T135_US        135
`define CPWE_T180_US        180
`define CPWE_T360_US        360
`define CPWE_T600_US        600

// Option codes on the option input (option n is code n-1)
`define CPWE_OPT1           3'h0
`define CPWE_OPT2           3'h1
`define CPWE_OPT3           3'h2
`define CPWE_OPT4           3'h3
`define CPWE_OPT5           3'h4
`define CPWE_OPT6           3'h5
`define CPWE_OPT7           3'h6
`define CPWE_OPT8           3'h7

`endif

/* File: design/cpwe_pkg.sv */
// Types shared by the crank pulse width encoder files.
// No assumptions about surroundings.
package cpwe_pkg;
	typedef enum logic [1:0] {
		CPWE_FWD,
		CPWE_BWD,
		CPWE_STAND,
		CPWE_NODIR
	} cpwe_kind_t;
endpackage

/* File: design/cpwe_sync.sv */
// Two-flop synchroniser for asynchronous level inputs.
// Assumes clk and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module cpwe_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// Data
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

/* File: design/cpwe_width_lut.sv */
// Width table: maps option and pulse kind to a terminal count in cycles.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
`include "cpwe_regs.svh"
module cpwe_width_lut
	import cpwe_pkg::*;
#(
	parameter int CW = 15
) (
	// Selection
	input  wire logic [2:0]    option,
	input  wire cpwe_kind_t    kind,
	// Terminal count
	output logic      [CW-1:0] cycles
);
	logic [15:0] width_us;

	always_comb begin
		width_us = 16'h0000;
		case (option)
			`CPWE_OPT1: width_us = (kind == CPWE_FWD) ? 16'(`CPWE_T45_US) :
				(kind == CPWE_BWD) ? 16'(`CPWE_T90_US) : 16'(`CPWE_T180_US);
			`CPWE_OPT2: width_us = (kind == CPWE_FWD) ? 16'(`CPWE_T45_US) :
				(kind == CPWE_BWD) ? 16'(`CPWE_T180_US) : 16'(`CPWE_T360_US);
			`CPWE_OPT3: width_us = (kind == CPWE_FWD) ? 16'(`CPWE_T45_US) :
				(kind == CPWE_BWD) ? 16'(`CPWE_T135_US) : 16'(`CPWE_T180_US);
			`CPWE_OPT4: width_us = (kind == CPWE_FWD) ? 16'(`CPWE_T75_US) :
				(kind == CPWE_BWD) ? 16'(`CPWE_T600_US) : 16'(`CPWE_T360_US);
			`CPWE_OPT5: width_us = (kind == CPWE_FWD) ? 16'(`CPWE_T22_US) :
				(kind == CPWE_BWD) ? 16'(`CPWE_T45_US) : 16'(`CPWE_T90_US);
			`CPWE_OPT6: width_us = (kind == CPWE_FWD) ? 16'(`CPWE_T60_US) :
				(kind == CPWE_BWD) ? 16'(`CPWE_T120_US) : 16'(`CPWE_T360_US);
			// Option 7 has no standstill width; backward width is reused
			`CPWE_OPT7: width_us = (kind == CPWE_FWD) ? 16'(`CPWE_T30_US) : 16'(`CPWE_T60_US);
			default:    width_us = (kind == CPWE_FWD) ? 16'(`CPWE_T90_US) :
				(kind == CPWE_BWD) ? 16'(`CPWE_T135_US) : 16'(`CPWE_T360_US);
		endcase
	end

	assign cycles = CW'(32'(width_us) * `CPWE_CYC_PER_US);
endmodule
`default_nettype wire

/* File: design/cpwe_encoder.sv */
// Crank pulse width encoder: turns wheel edge and standstill events into low pulses or level toggles on
// one open-drain output. Edge, direction and standstill inputs come from
// the sensing path in another domain and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "cpwe_regs.svh"

module cpwe_encoder
	import cpwe_pkg::*;
#(
	parameter int CW = 15
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Configuration, held static after power-on
	input  wire logic [2:0] option,
	input  wire logic       no_dir_mode,
	// Wheel events from the sensing path (asynchronous levels)
	input  wire logic       wheel_edge,
	input  wire logic       dir_backward,
	input  wire logic       standstill,
	// Open-drain output: drive low when q_oe_b is low
	input  wire logic       q_in,
	output logic            q_out,
	output logic            q_oe_b,
	// Status
	output logic            pulse_busy
);
	logic [1:0]    rst_pipe;
	logic          rst_int_b;
	logic [2:0]    in_sync;
	logic          edge_s;
	logic          bwd_s;
	logic          stand_s;
	logic          edge_prev;
	logic          stand_prev;
	logic          last_bwd;
	logic          toggle_lvl;
	logic          busy;
	logic [CW-1:0] count;
	logic [CW-1:0] term;
	logic [2:0]    opt_q;
	logic          nodir_q;
	logic          cfg_loaded;
	cpwe_kind_t    kind;
	logic [CW-1:0] lut_cycles;
	logic [CW-1:0] busy_len;
	logic [1:0]    warm;
	logic          armed;

	// Reset release through two flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_int_b = rst_pipe[1];

	cpwe_sync #(.WIDTH(3)) u_sync (
		.clk   (clk),
		.rst_b (rst_int_b),
		.d     ({wheel_edge, dir_backward, standstill}),
		.q     (in_sync)
	);
	assign edge_s  = in_sync[2];
	assign bwd_s   = in_sync[1];
	assign stand_s = in_sync[0];

	// Configuration latched once after reset release
	// option select
	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			opt_q      <= 3'h0;
			nodir_q    <= 1'b0;
			cfg_loaded <= 1'b0;
		end else if (!cfg_loaded) begin
			opt_q      <= option;
			nodir_q    <= no_dir_mode;
			cfg_loaded <= 1'b1;
		end
	end

	// Hold off events until the synchronisers and the edge history carry real levels;
	// a wheel level left high across reset would otherwise look like an edge
	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			warm <= 2'h0;
		end else if (!armed) begin
			warm <= warm + 2'h1;
		end
	end
	assign armed = (warm == 2'h3);

	wire edge_evt   = armed && (edge_s != edge_prev);
	wire stand_evt  = armed && stand_s && !stand_prev;
	wire opt7       = (opt_q == `CPWE_OPT7);
	wire opt7_first = opt7 && !bwd_s && last_bwd;
	wire toggle_evt = edge_evt && (nodir_q || (opt7 && !bwd_s && !last_bwd));
	wire pulse_evt  = !busy && ((edge_evt && !toggle_evt) || (stand_evt && !nodir_q && !opt7));
	wire done       = busy && (count == term - CW'(1));

	assign kind = stand_evt && !edge_evt ? CPWE_STAND : (bwd_s ? CPWE_BWD : CPWE_FWD);

	cpwe_width_lut #(.CW(CW)) u_lut (
		.option (opt_q),
		.kind   (kind),
		.cycles (lut_cycles)
	);

	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			edge_prev  <= 1'b0;
			stand_prev <= 1'b0;
			// Start as if backward so the first option-7 edge is a forward pulse
			last_bwd   <= 1'b1;
		end else begin
			edge_prev  <= edge_s;
			stand_prev <= stand_s;
			if (edge_evt && !nodir_q) begin
				last_bwd <= bwd_s;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			busy  <= 1'b0;
			count <= '0;
			term  <= '0;
		end else if (pulse_evt) begin
			busy  <= 1'b1;
			count <= '0;
			term  <= lut_cycles;
		end else if (done) begin
			busy  <= 1'b0;
		end else if (busy) begin
			count <= count + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			toggle_lvl <= 1'b1;
		end else if (toggle_evt) begin
			toggle_lvl <= !toggle_lvl;
		end else if (!nodir_q && !opt7) begin
			toggle_lvl <= 1'b1;
		end else if (opt7 && pulse_evt) begin
			toggle_lvl <= 1'b1;
		end
	end

	// Independent length count for the width assertion
	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			busy_len <= '0;
		end else if (pulse_evt) begin
			busy_len <= '0;
		end else if (busy) begin
			busy_len <= busy_len + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			q_out      <= 1'b0;
			q_oe_b     <= 1'b1;
			pulse_busy <= 1'b0;
		end else begin
			q_out      <= 1'b0;
			q_oe_b     <= !(busy || !toggle_lvl);
			pulse_busy <= busy;
		end
	end

	// Output pin readback is not needed by this encoder
	wire unused_q = q_in;

	// Assertions
	// Pulse of fixed kind lasts exactly its terminal count
	property p_width;
		@(posedge clk) disable iff (!rst_int_b)
		$fell(busy) |-> (busy_len == term);
	endproperty
	a_width: assert property (p_width) else $error("pulse counter exceeded terminal count");

	property p_low_during_pulse;
		@(posedge clk) disable iff (!rst_int_b)
		busy |=> !q_oe_b;
	endproperty
	a_low_during_pulse: assert property (p_low_during_pulse) else $error("output not low during pulse");

	property p_opt3_fwd;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT3 && kind == CPWE_FWD) |=> (term == CW'(2250));
	endproperty
	a_opt3_fwd: assert property (p_opt3_fwd) else $error("option 3 forward width wrong");

	property p_opt4_bwd;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT4 && kind == CPWE_BWD) |=> (term == CW'(30000));
	endproperty
	a_opt4_bwd: assert property (p_opt4_bwd) else $error("option 4 backward width wrong");

	property p_opt5_stand;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT5 && kind == CPWE_STAND) |=> (term == CW'(4500));
	endproperty
	a_opt5_stand: assert property (p_opt5_stand) else $error("option 5 standstill width wrong");

	property p_opt6_bwd;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT6 && kind == CPWE_BWD) |=> (term == CW'(6000));
	endproperty
	a_opt6_bwd: assert property (p_opt6_bwd) else $error("option 6 backward width wrong");

	property p_opt7_fwd;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt7 && kind == CPWE_FWD) |=> (term == CW'(1500));
	endproperty
	a_opt7_fwd: assert property (p_opt7_fwd) else $error("option 7 forward width wrong");

	property p_opt2_stand;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT2 && kind == CPWE_STAND) |=> (term == CW'(18000));
	endproperty
	a_opt2_stand: assert property (p_opt2_stand) else $error("option 2 standstill width wrong");

	property p_nodir_toggle;
		@(posedge clk) disable iff (!rst_int_b)
		(edge_evt && nodir_q) |=> (toggle_lvl != $past(toggle_lvl));
	endproperty
	a_nodir_toggle: assert property (p_nodir_toggle) else $error("no-direction edge did not toggle");

	property p_opt1_bwd;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT1 && kind == CPWE_BWD) |=> (term == CW'(4500));
	endproperty
	a_opt1_bwd: assert property (p_opt1_bwd) else $error("option 1 backward width wrong");

	property p_opt2_bwd;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT2 && kind == CPWE_BWD) |=> (term == CW'(9000));
	endproperty
	a_opt2_bwd: assert property (p_opt2_bwd) else $error("option 2 backward width wrong");

	property p_opt3_stand;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT3 && kind == CPWE_STAND) |=> (term == CW'(9000));
	endproperty
	a_opt3_stand: assert property (p_opt3_stand) else $error("option 3 standstill width wrong");

	property p_opt4_fwd;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT4 && kind == CPWE_FWD) |=> (term == CW'(3750));
	endproperty
	a_opt4_fwd: assert property (p_opt4_fwd) else $error("option 4 forward width wrong");

	property p_opt6_stand;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT6 && kind == CPWE_STAND) |=> (term == CW'(18000));
	endproperty
	a_opt6_stand: assert property (p_opt6_stand) else $error("option 6 standstill width wrong");

	property p_opt7_bwd;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt7 && kind == CPWE_BWD) |=> (term == CW'(3000));
	endproperty
	a_opt7_bwd: assert property (p_opt7_bwd) else $error("option 7 backward width wrong");

	property p_opt8_fwd;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT8 && kind == CPWE_FWD) |=> (term == CW'(4500));
	endproperty
	a_opt8_fwd: assert property (p_opt8_fwd) else $error("option 8 forward width wrong");

	property p_opt8_stand;
		@(posedge clk) disable iff (!rst_int_b)
		(pulse_evt && opt_q == `CPWE_OPT8 && kind == CPWE_STAND) |=> (term == CW'(18000));
	endproperty
	a_opt8_stand: assert property (p_opt8_stand) else $error("option 8 standstill width wrong");

	// Forward pulses in option 7 only follow a backward history
	property p_opt7_once;
		@(posedge clk) disable iff (!rst_int_b)
		(opt7 && pulse_evt && !bwd_s) |-> opt7_first;
	endproperty
	a_opt7_once: assert property (p_opt7_once) else $error("option 7 repeated forward pulse");

	// Pulse end: timer stops while the toggle level is high
	sequence s_pulse_end;
		$fell(busy) && toggle_lvl;
	endsequence
	property p_release;
		@(posedge clk) disable iff (!rst_int_b)
		s_pulse_end |=> $rose(q_oe_b);
	endproperty
	a_release: assert property (p_release) else $error("output not released after pulse");
endmodule
`default_nettype wire

/* File: tb/cpwe_ecu_model.sv */
// Engine control unit model: times each low period on the sensor pin.
// Assumes a pull-up on the pin and the bench clock.
`timescale 1ns/10ps
`default_nettype none
module cpwe_ecu_model (
	// Clock
	input  wire logic        clk,
	// Pin level
	input  wire logic        pin,
	// Measured pulses
	output logic      [15:0] low_len,
	output logic      [15:0] npls
);
	logic [15:0] cnt = 16'h0;
	logic [15:0] last_len = 16'h0;
	logic [15:0] pulses = 16'h0;
	assign low_len = last_len;
	assign npls = pulses;
	always @(posedge clk) begin
		if (pin === 1'b0) begin
			cnt <= cnt + 16'h1;
		end else if (cnt != 16'h0) begin
			last_len <= cnt;
			pulses <= pulses + 16'h1;
			cnt <= 16'h0;
		end
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Bench for the crank pulse width encoder with an ECU model on the pin.
// Assumes a 50 MHz clock; option is latched after each reset.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [2:0]  option = 3'h0;
	logic        no_dir_mode = 1'b0;
	logic        wheel_edge = 1'b0;
	logic        dir_backward = 1'b0;
	logic        standstill = 1'b0;
	logic        q_out;
	logic        q_oe_b;
	logic        pulse_busy;
	logic        pin;
	logic [15:0] low_len;
	logic [15:0] npls;
	logic [15:0] n0;
	int          mismatches = 0;
	int          checked = 0;
	int          tw [7][4] = '{'{0, 45, 90, 0}, '{1, 45, 0, 360}, '{2, 45, 135, 0},
		'{3, 75, 0, 0}, '{4, 22, 45, 90}, '{5, 60, 120, 0}, '{7, 90, 135, 0}};

	// Pull-up on the pin
	assign pin = (q_oe_b === 1'b0) ? q_out : 1'b1;
	always #10 clk = ~clk;

	cpwe_encoder DUT (.clk(clk), .rst_b(rst_b), .option(option), .no_dir_mode(no_dir_mode),
		.wheel_edge(wheel_edge), .dir_backward(dir_backward), .standstill(standstill),
		.q_in(pin), .q_out(q_out), .q_oe_b(q_oe_b), .pulse_busy(pulse_busy));
	cpwe_ecu_model ecu (.clk(clk), .pin(pin), .low_len(low_len), .npls(npls));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic boot(input logic [2:0] opt, input logic nd);
		rst_b <= 1'b0;
		option <= opt;
		no_dir_mode <= nd;
		cyc(2);
		rst_b <= 1'b1;
		cyc(12);
	endtask
	task automatic ev(input logic bwd, input logic st);
		n0 = npls;
		dir_backward <= bwd;
		cyc(1);
		if (st) begin
			standstill <= 1'b1;
		end else begin
			wheel_edge <= ~wheel_edge;
		end
		cyc(1);
	endtask
	task automatic pulse(input string nm, input int us);
		int i;
		for (i = 0; i < 40000 && npls == n0; i++) cyc(1);
		if (npls == n0) begin
			mismatches++;
			$display("Error %s expected pulse seen none", nm);
			test_done();
		end
		chk(nm, 16'(us * 50), low_len);
		standstill <= 1'b0;
		cyc(6);
	endtask
	task automatic t_widths;
		for (int i = 0; i < 7; i++) begin
			boot(3'(tw[i][0]), 1'b0);
			ev(1'b0, 1'b0);
			pulse("fwd width", tw[i][1]);
			if (tw[i][2] > 0) begin
				ev(1'b1, 1'b0);
				pulse("bwd width", tw[i][2]);
			end
			if (tw[i][3] > 0) begin
				ev(1'b1, 1'b1);
				pulse("stand width", tw[i][3]);
			end
		end
		$display("widths test done");
	endtask
	task automatic t_opt7;
		boot(3'h6, 1'b0);
		ev(1'b0, 1'b0);
		pulse("opt7 fwd", 30);
		ev(1'b0, 1'b0);
		cyc(10);
		chk("opt7 level", 16'h0, {15'h0, pin});
		ev(1'b0, 1'b0);
		cyc(10);
		chk("opt7 level", 16'h1, {15'h0, pin});
		ev(1'b1, 1'b0);
		pulse("opt7 bwd", 60);
		ev(1'b0, 1'b0);
		pulse("opt7 rearm", 30);
		$display("opt7 test done");
	endtask
	task automatic t_nodir;
		boot(3'h0, 1'b1);
		ev(1'b0, 1'b0);
		cyc(10);
		chk("nodir level", 16'h0, {15'h0, pin});
		ev(1'b1, 1'b0);
		cyc(10);
		chk("nodir level", 16'h1, {15'h0, pin});
		$display("nodir test done");
	endtask
	task automatic t_refuse;
		boot(3'h4, 1'b0);
		ev(1'b0, 1'b0);
		cyc(200);
		chk("busy", 16'h1, {15'h0, pulse_busy});
		chk("q_out", 16'h0, {15'h0, q_out});
		ev(1'b0, 1'b0);
		pulse("refuse width", 22);
		cyc(1500);
		chk("refuse count", n0 + 16'h1, npls);
		$display("refuse test done");
	endtask

	initial begin
		t_widths();
		t_opt7();
		t_nodir();
		t_refuse();
		test_done();
	end
endmodule
`default_nettype wire
